/* pkg/fbp_cfg.svh */
/*
 * constants of the flash block-protection host: command codes, unlock
 * addresses, bus timing.
 * assumes a word-wide (x16) device and a 5 ns system clock.
 */
`ifndef FBP_CFG_SVH
`define FBP_CFG_SVH

// ==========================================================
// unlock preamble and command codes
`define FBP_A_UNLK1      32'h0000_0555
`define FBP_A_UNLK2      32'h0000_02aa
`define FBP_A_ZERO       32'h0000_0000
`define FBP_A_ASEL_PROT  32'h0000_0002
`define FBP_D_UNLK1      16'h00aa
`define FBP_D_UNLK2      16'h0055
`define FBP_D_LOCKREG    16'h0040
`define FBP_D_PWD        16'h0060
`define FBP_D_NVP        16'h00c0
`define FBP_D_ASEL       16'h0090
`define FBP_D_RESET      16'h00f0
`define FBP_D_PROG       16'h00a0
`define FBP_D_EXIT1      16'h0090
`define FBP_D_EXIT2      16'h0000
`define FBP_D_UNLOCK1    16'h0025
`define FBP_D_UNLOCK2    16'h0003
`define FBP_D_UNLOCK_CF  16'h0029
`define FBP_D_NVP_SET    16'h0000
`define FBP_D_CLR1       16'h0080
`define FBP_D_CLR2       16'h0030

// ==========================================================
// lock register field and password layout
`define FBP_LR_PWD_BIT   2
`define FBP_PWD_WORDS    4

// ==========================================================
// bus timing
`define FBP_CLK_NS       5
`define FBP_T_WP_NS      50
`define FBP_T_ACC_NS     100
`define FBP_T_GAP_NS     30
`define FBP_SYNC_CYC     2

`endif

/* pkg/fbp_pkg.sv */
/*
 * types of the flash block-protection host.
 * assumes nothing beyond the tool's SystemVerilog support.
 */
package fbp_pkg;

	// ==========================================================
	// operations that the user may order
	typedef enum logic [3:0] {
		OP_ENTER_LOCKREG,
		OP_ENTER_PWD,
		OP_ENTER_NVP,
		OP_EXIT,
		OP_PROG_LOCKREG,
		OP_PROG_PWD,
		OP_READ_PWD,
		OP_UNLOCK_PWD,
		OP_PROG_NVP,
		OP_READ_NVP,
		OP_CLEAR_NVP,
		OP_READ_STATUS
	} fbp_op_t;

	typedef enum logic [1:0] {
		MD_NONE,
		MD_LOCKREG,
		MD_PWD,
		MD_NVP
	} fbp_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} fbp_state_t;

	// one user order
	typedef struct packed {
		fbp_op_t     op;
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [1:0]  idx;
	} fbp_cmd_t;

	// one bus cycle of a sequence
	typedef struct packed {
		logic        rd;
		logic        last;
		logic [31:0] addr;
		logic [15:0] data;
	} fbp_cyc_t;

endpackage

/* verilog/fbp_host.sv */
/*
 * host controller that drives the protection command sets of a parallel
 * NOR flash over its address, data and strobe pins (word mode).
 * assumes the data pins are resolved outside from dq_o/dq_oe_o and that
 * dq_i arrives asynchronously.
 */
// Functional notes
// - host programs and verifies the 64-bit password before activating.
// - protection status is read in auto-select mode.
// - lock-register set entered by AAh, 55h, 40h at 555, 2AA, 555.
// - every protection set is left by 90h then 00h.
// - password set entered by preamble AAh, 55h, then 60h.
// - password portion programmed by A0h, then the portion at its address.
// - unlock is 25h, 03h at 00, four words, then 29h at 00.
// - nonvolatile bit set by A0h, then 00h inside the block.
// - all nonvolatile bits cleared by 80h, then 30h at 00.
// - an entered set must be exited; other orders are refused with err until then.
`timescale 1ns/1ps
`include "fbp_cfg.svh"

module fbp_host #(
	parameter int AW = 25
) (
	// clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              en_i,
	// user orders
	input  wire logic              cmd_valid_i,
	input  wire fbp_pkg::fbp_cmd_t cmd_i,
	output logic                   cmd_ready_o,
	output logic                   done_o,
	output logic                   err_o,
	output logic [63:0]            rdata_o,
	output logic [1:0]             mode_o,
	output logic                   pwd_mode_o,
	output logic                   pwd_ok_o,
	// flash pins
	output logic [AW-1:0]          addr_o,
	output logic [15:0]            dq_o,
	output logic                   dq_oe_o,
	input  wire logic [15:0]       dq_i,
	output logic                   ce_n_o,
	output logic                   we_n_o,
	output logic                   oe_n_o
);

	localparam logic [7:0] WP_CYC  = 8'((`FBP_T_WP_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS);
	localparam logic [7:0] ACC_CYC = 8'((`FBP_T_ACC_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS
		+ `FBP_SYNC_CYC);
	localparam logic [7:0] GAP_CYC = 8'((`FBP_T_GAP_NS + `FBP_CLK_NS - 1) / `FBP_CLK_NS);

	// ==========================================================
	// input synchroniser
	logic [15:0] dq_s1_r;
	logic [15:0] dq_s2_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dq_s1_r <= 16'h0000;
			dq_s2_r <= 16'h0000;
		end else if (en_i) begin
			dq_s1_r <= dq_i;
			dq_s2_r <= dq_s1_r;
		end
	end

	// ==========================================================
	// state
	fbp_pkg::fbp_state_t state_r, state_nxt;
	fbp_pkg::fbp_mode_t  mode_r, mode_nxt;
	fbp_pkg::fbp_cmd_t   cmd_r, cmd_nxt;
	fbp_pkg::fbp_cyc_t   cyc;
	logic [7:0]          cnt_r, cnt_nxt;
	logic [2:0]          step_r, step_nxt;
	logic                pwd_mode_r, pwd_mode_nxt;
	logic [63:0]         pwd_r, pwd_nxt;
	logic [3:0]          pmask_r, pmask_nxt;
	logic                match_r, match_nxt;
	logic                pwd_ok_r, pwd_ok_nxt;
	logic [63:0]         rdata_r, rdata_nxt;
	logic                done_r, done_nxt;
	logic                err_r, err_nxt;
	logic [AW-1:0]       addr_r, addr_nxt;
	logic [15:0]         dq_r, dq_nxt;
	logic                dq_oe_r, dq_oe_nxt;
	logic                ce_n_r, ce_n_nxt;
	logic                we_n_r, we_n_nxt;
	logic                oe_n_r, oe_n_nxt;
	logic                legal;
	logic [1:0]          widx;

	// ==========================================================
	// bus cycle of the current step
	always_comb begin
		cyc  = '{rd: 1'b0, last: 1'b0, addr: `FBP_A_ZERO, data: `FBP_D_EXIT2};
		widx = 2'(step_r - 3'h2);
		unique case (cmd_r.op)
			fbp_pkg::OP_ENTER_LOCKREG, fbp_pkg::OP_ENTER_PWD, fbp_pkg::OP_ENTER_NVP,
			fbp_pkg::OP_READ_STATUS: begin
				unique case (step_r)
					3'h0: begin
						cyc.addr = `FBP_A_UNLK1;
						cyc.data = `FBP_D_UNLK1;
					end
					3'h1: begin
						cyc.addr = `FBP_A_UNLK2;
						cyc.data = `FBP_D_UNLK2;
					end
					3'h2: begin
						cyc.addr = `FBP_A_UNLK1;
						cyc.last = (cmd_r.op != fbp_pkg::OP_READ_STATUS);
						if (cmd_r.op == fbp_pkg::OP_ENTER_LOCKREG)
							cyc.data = `FBP_D_LOCKREG;
						else if (cmd_r.op == fbp_pkg::OP_ENTER_PWD)
							cyc.data = `FBP_D_PWD;
						else if (cmd_r.op == fbp_pkg::OP_ENTER_NVP)
							cyc.data = `FBP_D_NVP;
						else
							cyc.data = `FBP_D_ASEL;
					end
					3'h3: begin
						cyc.rd   = 1'b1;
						cyc.addr = cmd_r.addr | `FBP_A_ASEL_PROT;
					end
					default: begin
						cyc.data = `FBP_D_RESET;
						cyc.last = 1'b1;
					end
				endcase
			end
			fbp_pkg::OP_EXIT: begin
				cyc.data = (step_r == 3'h0) ? `FBP_D_EXIT1 : `FBP_D_EXIT2;
				cyc.last = (step_r == 3'h1);
			end
			fbp_pkg::OP_PROG_LOCKREG, fbp_pkg::OP_PROG_PWD, fbp_pkg::OP_PROG_NVP: begin
				cyc.last = (step_r == 3'h1);
				if (step_r == 3'h0)
					cyc.data = `FBP_D_PROG;
				else if (cmd_r.op == fbp_pkg::OP_PROG_LOCKREG)
					cyc.data = cmd_r.wdata[15:0];
				else if (cmd_r.op == fbp_pkg::OP_PROG_PWD) begin
					cyc.addr = 32'(cmd_r.idx);
					cyc.data = cmd_r.wdata[16*cmd_r.idx +: 16];
				end else begin
					cyc.addr = cmd_r.addr;
					cyc.data = `FBP_D_NVP_SET;
				end
			end
			fbp_pkg::OP_READ_PWD: begin
				cyc.rd   = 1'b1;
				cyc.addr = 32'(step_r);
				cyc.last = (step_r == 3'h3);
			end
			fbp_pkg::OP_UNLOCK_PWD: begin
				cyc.last = (step_r == 3'h6);
				if (step_r == 3'h0)
					cyc.data = `FBP_D_UNLOCK1;
				else if (step_r == 3'h1)
					cyc.data = `FBP_D_UNLOCK2;
				else if (step_r == 3'h6)
					cyc.data = `FBP_D_UNLOCK_CF;
				else begin
					cyc.addr = 32'(widx);
					cyc.data = cmd_r.wdata[16*widx +: 16];
				end
			end
			fbp_pkg::OP_READ_NVP: begin
				cyc.rd   = 1'b1;
				cyc.addr = cmd_r.addr;
				cyc.last = 1'b1;
			end
			fbp_pkg::OP_CLEAR_NVP: begin
				cyc.data = (step_r == 3'h0) ? `FBP_D_CLR1 : `FBP_D_CLR2;
				cyc.last = (step_r == 3'h1);
			end
			default: begin
				cyc.last = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// legality of a new order in the current command set
	always_comb begin
		unique case (cmd_i.op)
			fbp_pkg::OP_ENTER_LOCKREG, fbp_pkg::OP_ENTER_PWD, fbp_pkg::OP_ENTER_NVP,
			fbp_pkg::OP_READ_STATUS:
				legal = (mode_r == fbp_pkg::MD_NONE);
			fbp_pkg::OP_EXIT:
				legal = (mode_r != fbp_pkg::MD_NONE);
			fbp_pkg::OP_PROG_LOCKREG:
				legal = (mode_r == fbp_pkg::MD_LOCKREG) &&
					(cmd_i.wdata[`FBP_LR_PWD_BIT] || pwd_ok_r);
			fbp_pkg::OP_PROG_PWD, fbp_pkg::OP_READ_PWD:
				legal = (mode_r == fbp_pkg::MD_PWD) && !pwd_mode_r;
			fbp_pkg::OP_UNLOCK_PWD:
				legal = (mode_r == fbp_pkg::MD_PWD);
			default:
				legal = (mode_r == fbp_pkg::MD_NVP);
		endcase
	end

	// ==========================================================
	// sequencer
	always_comb begin
		state_nxt    = state_r;
		mode_nxt     = mode_r;
		cmd_nxt      = cmd_r;
		cnt_nxt      = cnt_r;
		step_nxt     = step_r;
		pwd_mode_nxt = pwd_mode_r;
		pwd_nxt      = pwd_r;
		pmask_nxt    = pmask_r;
		match_nxt    = match_r;
		pwd_ok_nxt   = pwd_ok_r;
		rdata_nxt    = rdata_r;
		done_nxt     = 1'b0;
		err_nxt      = 1'b0;
		addr_nxt     = addr_r;
		dq_nxt       = dq_r;
		dq_oe_nxt    = dq_oe_r;
		ce_n_nxt     = ce_n_r;
		we_n_nxt     = we_n_r;
		oe_n_nxt     = oe_n_r;
		unique case (state_r)
			fbp_pkg::ST_IDLE: begin
				if (cmd_valid_i && legal) begin
					cmd_nxt   = cmd_i;
					step_nxt  = 3'h0;
					match_nxt = 1'b1;
					state_nxt = fbp_pkg::ST_SETUP;
				end else if (cmd_valid_i) begin
					err_nxt = 1'b1;
				end
			end
			fbp_pkg::ST_SETUP: begin
				addr_nxt  = cyc.addr[AW-1:0];
				dq_nxt    = cyc.data;
				dq_oe_nxt = !cyc.rd;
				ce_n_nxt  = 1'b0;
				cnt_nxt   = 8'h00;
				state_nxt = fbp_pkg::ST_STROBE;
			end
			fbp_pkg::ST_STROBE: begin
				we_n_nxt = cyc.rd;
				oe_n_nxt = !cyc.rd;
				cnt_nxt  = cnt_r + 8'h01;
				if (cnt_r == (cyc.rd ? ACC_CYC : WP_CYC)) begin
					we_n_nxt  = 1'b1;
					oe_n_nxt  = 1'b1;
					cnt_nxt   = 8'h00;
					state_nxt = fbp_pkg::ST_HOLD;
					if (cyc.rd && cmd_r.op == fbp_pkg::OP_READ_PWD) begin
						rdata_nxt[16*step_r[1:0] +: 16] = dq_s2_r;
						match_nxt = match_r && (dq_s2_r == pwd_r[16*step_r[1:0] +: 16]);
					end else if (cyc.rd && cmd_r.op == fbp_pkg::OP_READ_NVP)
						rdata_nxt = {63'h0, dq_s2_r[0]};
					else if (cyc.rd)
						rdata_nxt = {56'h0, dq_s2_r[7:0]};
				end
			end
			fbp_pkg::ST_HOLD: begin
				ce_n_nxt  = 1'b1;
				dq_oe_nxt = 1'b0;
				cnt_nxt   = cnt_r + 8'h01;
				if (cnt_r == GAP_CYC) begin
					cnt_nxt   = 8'h00;
					step_nxt  = step_r + 3'h1;
					state_nxt = fbp_pkg::ST_SETUP;
					if (cyc.last) begin
						state_nxt = fbp_pkg::ST_IDLE;
						done_nxt  = 1'b1;
						unique case (cmd_r.op)
							fbp_pkg::OP_ENTER_LOCKREG: mode_nxt = fbp_pkg::MD_LOCKREG;
							fbp_pkg::OP_ENTER_PWD:     mode_nxt = fbp_pkg::MD_PWD;
							fbp_pkg::OP_ENTER_NVP:     mode_nxt = fbp_pkg::MD_NVP;
							fbp_pkg::OP_EXIT:          mode_nxt = fbp_pkg::MD_NONE;
							fbp_pkg::OP_PROG_LOCKREG:
								if (!cmd_r.wdata[`FBP_LR_PWD_BIT])
									pwd_mode_nxt = 1'b1;
							fbp_pkg::OP_PROG_PWD: begin
								pwd_nxt[16*cmd_r.idx +: 16] = cmd_r.wdata[16*cmd_r.idx +: 16];
								pmask_nxt[cmd_r.idx]        = 1'b1;
								pwd_ok_nxt                  = 1'b0;
							end
							fbp_pkg::OP_READ_PWD:
								pwd_ok_nxt = (&pmask_r) && match_r;
							default: begin
							end
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r    <= fbp_pkg::ST_IDLE;
			mode_r     <= fbp_pkg::MD_NONE;
			cmd_r      <= '0;
			cnt_r      <= 8'h00;
			step_r     <= 3'h0;
			pwd_mode_r <= 1'b0;
			pwd_r      <= 64'h0;
			pmask_r    <= 4'h0;
			match_r    <= 1'b0;
			pwd_ok_r   <= 1'b0;
			rdata_r    <= 64'h0;
			done_r     <= 1'b0;
			err_r      <= 1'b0;
			addr_r     <= '0;
			dq_r       <= 16'h0000;
			dq_oe_r    <= 1'b0;
			ce_n_r     <= 1'b1;
			we_n_r     <= 1'b1;
			oe_n_r     <= 1'b1;
		end else if (en_i) begin
			state_r    <= state_nxt;
			mode_r     <= mode_nxt;
			cmd_r      <= cmd_nxt;
			cnt_r      <= cnt_nxt;
			step_r     <= step_nxt;
			pwd_mode_r <= pwd_mode_nxt;
			pwd_r      <= pwd_nxt;
			pmask_r    <= pmask_nxt;
			match_r    <= match_nxt;
			pwd_ok_r   <= pwd_ok_nxt;
			rdata_r    <= rdata_nxt;
			done_r     <= done_nxt;
			err_r      <= err_nxt;
			addr_r     <= addr_nxt;
			dq_r       <= dq_nxt;
			dq_oe_r    <= dq_oe_nxt;
			ce_n_r     <= ce_n_nxt;
			we_n_r     <= we_n_nxt;
			oe_n_r     <= oe_n_nxt;
		end
	end

	assign cmd_ready_o = (state_r == fbp_pkg::ST_IDLE);
	assign done_o      = done_r;
	assign err_o       = err_r;
	assign rdata_o     = rdata_r;
	assign mode_o      = mode_r;
	assign pwd_mode_o  = pwd_mode_r;
	assign pwd_ok_o    = pwd_ok_r;
	assign addr_o      = addr_r;
	assign dq_o        = dq_r;
	assign dq_oe_o     = dq_oe_r;
	assign ce_n_o      = ce_n_r;
	assign we_n_o      = we_n_r;
	assign oe_n_o      = oe_n_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_STROBE_EXCL: assert property (!(!we_n_o && !oe_n_o))
		else $error("write and read strobe low together");
	AST_WE_WIDTH: assert property ($fell(we_n_o) |-> !we_n_o [*8])
		else $error("write strobe too short");
	AST_READ_NO_DRIVE: assert property (!oe_n_o |-> !dq_oe_o && !ce_n_o)
		else $error("host drives data during a read");
	AST_PWD_LOCKED: assert property (en_i && cmd_ready_o && cmd_valid_i && pwd_mode_o &&
		cmd_i.op == fbp_pkg::OP_READ_PWD |=> err_o)
		else $error("password readback not refused in password mode");
	AST_SET_ORDER: assert property (en_i && cmd_ready_o && cmd_valid_i &&
		cmd_i.op == fbp_pkg::OP_PROG_NVP && mode_o != fbp_pkg::MD_NVP |=> err_o)
		else $error("nonvolatile order outside its command set");
	AST_VERIFY_FIRST: assert property (en_i && cmd_ready_o && cmd_valid_i && !pwd_ok_o &&
		cmd_i.op == fbp_pkg::OP_PROG_LOCKREG && !cmd_i.wdata[`FBP_LR_PWD_BIT] |=> err_o)
		else $error("password mode activated before verification");
	AST_EXIT_MODE: assert property (done_o && cmd_r.op == fbp_pkg::OP_EXIT |->
		mode_o == fbp_pkg::MD_NONE)
		else $error("exit did not leave the command set");
	AST_ENTER_FIRST: assert property ($fell(we_n_o) && step_r == 3'h0 &&
		cmd_r.op == fbp_pkg::OP_ENTER_LOCKREG |->
		addr_o == AW'(`FBP_A_UNLK1) && dq_o == `FBP_D_UNLK1)
		else $error("enter sequence does not start with the unlock cycle");
	AST_UNLOCK_CONFIRM: assert property ($fell(we_n_o) && step_r == 3'h6 &&
		cmd_r.op == fbp_pkg::OP_UNLOCK_PWD |->
		addr_o == AW'(`FBP_A_ZERO) && dq_o == `FBP_D_UNLOCK_CF)
		else $error("unlock not confirmed at address zero");
	AST_ACTIVATE: assert property (done_o && cmd_r.op == fbp_pkg::OP_PROG_LOCKREG &&
		!cmd_r.wdata[`FBP_LR_PWD_BIT] |-> pwd_mode_o)
		else $error("password mode not recorded");

	COV_NVP_ENTER: cover property (done_o && cmd_r.op == fbp_pkg::OP_ENTER_NVP);
	COV_UNLOCK: cover property (done_o && cmd_r.op == fbp_pkg::OP_UNLOCK_PWD);
	COV_STATUS: cover property (done_o && cmd_r.op == fbp_pkg::OP_READ_STATUS);
	COV_REFUSED: cover property (err_o);

endmodule

/* sim/fbp_flash_model.sv */
/*
 * behavioural model of the flash protection logic, word mode.
 * assumes the bench resolves the data bus and drives the hardware reset.
 */
`timescale 1ns/1ps

module fbp_flash_model #(
	parameter int AW    = 25,
	parameter int RD_NS = 90
) (
	// hardware reset
	input  wire logic          rst_n_i,
	// bus pins
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [15:0]   dq_i,
	output logic [15:0]        dq_o,
	input  wire logic          ce_n_i,
	input  wire logic          we_n_i,
	input  wire logic          oe_n_i
);
	// ==========================================================
	// protection state
	logic [7:0]  nvb      = '1;
	logic [7:0]  vb       = '1;
	logic [15:0] lreg     = '1;
	logic [63:0] pwd      = '1;
	logic [63:0] got;
	logic        pwd_mode = 1'b0;
	logic        lock_b   = 1'b1;
	logic [2:0]  md       = '0;
	logic [1:0]  cyc      = '0;
	logic [7:0]  pend     = '0;
	logic [2:0]  n;
	logic [15:0] rd_val;
	logic [15:0] last_q   = '0;
	logic [2:0]  blk;
	assign blk = addr_i[18:16];

	// ==========================================================
	// write decode; md: 1 lock reg, 2 password, 3 nonvolatile, 4 auto-select
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		if (md == 3'h0) begin
			if (cyc == 2'h0 && a == 16'h0555 && d[7:0] == 8'haa)
				cyc = 2'h1;
			else if (cyc == 2'h1 && a == 16'h02aa && d[7:0] == 8'h55)
				cyc = 2'h2;
			else begin
				if (cyc == 2'h2 && a == 16'h0555) begin
					case (d[7:0])
						8'h40: md = 3'h1;
						8'h60: md = 3'h2;
						8'hc0: md = 3'h3;
						8'h90: md = 3'h4;
						default: md = 3'h0;
					endcase
				end
				cyc = 2'h0;
			end
		end else if (md == 3'h4) begin
			if (d[7:0] == 8'hf0)
				md = 3'h0;
		end else if (pend == 8'h90) begin
			if (d[7:0] == 8'h00)
				md = 3'h0;
			pend = 8'h00;
		end else if (pend == 8'ha0) begin
			if (md == 3'h1)
				lreg = lreg & d;
			if (md == 3'h1 && !d[2])
				pwd_mode = 1'b1;
			if (md == 3'h2 && !pwd_mode)
				pwd[a[1:0]*16 +: 16] = d;
			if (md == 3'h3 && lock_b && d == 16'h0000)
				nvb[blk] = 1'b0;
			pend = 8'h00;
		end else if (pend == 8'h80) begin
			if (md == 3'h3 && lock_b && a == 16'h0000 && d[7:0] == 8'h30)
				nvb = '1;
			pend = 8'h00;
		end else if (pend == 8'h25) begin
			pend = (d[7:0] == 8'h03) ? 8'h03 : 8'h00;
			n = 3'h0;
		end else if (pend == 8'h03) begin
			if (n < 3'h4) begin
				got[a[1:0]*16 +: 16] = d;
				n = n + 3'h1;
			end else begin
				if (d[7:0] == 8'h29 && got == pwd)
					lock_b = 1'b1;
				pend = 8'h00;
			end
		end else if (d[7:0] == 8'h90 || d[7:0] == 8'ha0 || d[7:0] == 8'h80)
			pend = d[7:0];
		else if (md == 3'h2 && d[7:0] == 8'h25)
			pend = d[7:0];
	endtask

	always @(posedge we_n_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vb = '1;
			lock_b = !pwd_mode;
			md = 3'h0;
			cyc = 2'h0;
			pend = 8'h00;
		end else if (!ce_n_i) begin
			wr(addr_i[15:0], dq_i);
		end
	end

	// ==========================================================
	// read data; released bus shows the inverse of the last value
	always_comb begin
		case (md)
			3'h1: rd_val = lreg;
			3'h2: rd_val = pwd_mode ? 16'hffff : pwd[addr_i[1:0]*16 +: 16];
			3'h3: rd_val = {15'h0000, nvb[blk]};
			3'h4: rd_val = {15'h0000, !(nvb[blk] && vb[blk])};
			default: rd_val = addr_i[15:0];
		endcase
	end

	always @(*) begin
		if (!ce_n_i && !oe_n_i)
			last_q = rd_val;
	end
	assign #(RD_NS) dq_o = (!ce_n_i && !oe_n_i) ? rd_val : ~last_q;
endmodule

/* sim/testbench.sv */
/*
 * self-checking bench of the protection host against the flash model.
 * assumes the package and the host as delivered, word mode.
 */
`timescale 1ns/1ps

module testbench;
	// ==========================================================
	// signals
	logic              clk_i       = 1'b0;
	logic              rstn_i      = 1'b0;
	logic              flash_rst_n = 1'b1;
	logic              en          = 1'b1;
	logic              cmd_valid   = 1'b0;
	fbp_pkg::fbp_cmd_t cmd         = '0;
	logic              ready, done, err, dq_oe, ce_n, we_n, oe_n, pwd_mode, pwd_ok;
	logic [63:0]       rdata;
	logic [1:0]        mode;
	logic [24:0]       addr;
	logic [15:0]       h_dq, f_dq, bus;
	int                fails       = 0;
	int                check_count = 0;
	int                n;
	localparam logic [63:0] PW = 64'h1357_9bdf_2468_ace0;
	localparam logic [31:0] B1 = 32'h0001_0000;
	localparam logic [31:0] B2 = 32'h0002_0000;

	always #2.5 clk_i = ~clk_i;
	assign bus = dq_oe ? h_dq : f_dq;

	fbp_host #(.AW(25)) fbp_host_i (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(ready), .done_o(done),
		.err_o(err), .rdata_o(rdata), .mode_o(mode), .pwd_mode_o(pwd_mode),
		.pwd_ok_o(pwd_ok), .addr_o(addr), .dq_o(h_dq), .dq_oe_o(dq_oe), .dq_i(bus),
		.ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n));

	fbp_flash_model #(.AW(25)) fbp_flash_model_i (.rst_n_i(flash_rst_n), .addr_i(addr),
		.dq_i(bus), .dq_o(f_dq), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n));

	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one order; n returns the cycles from take to done or err
	task automatic op(input fbp_pkg::fbp_op_t o, input logic [31:0] a,
		input logic [63:0] w, input logic [1:0] ix, input logic e);
		logic hang;
		hang = 1'b0;
		// one idle edge keeps valid low between back-to-back orders
		@(posedge clk_i);
		#1;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		hang = (n >= 50);
		cmd = '{op: o, addr: a, wdata: w, idx: ix};
		cmd_valid = 1'b1;
		@(posedge clk_i);
		#1;
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && err !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (hang || n >= 2000) begin
			fails++;
			final_report();
		end else
			chk("outcome", {62'h0, e, !e}, {62'h0, err, done});
	endtask

	task automatic ok(input fbp_pkg::fbp_op_t o, input logic [31:0] a, input logic [63:0] w);
		op(o, a, w, 2'h0, 1'b0);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_refuse();
		chk("strobes", 64'h7, {61'h0, ce_n, we_n, oe_n});
		en = 1'b0;
		cmd = '{op: fbp_pkg::OP_EXIT, addr: '0, wdata: '0, idx: 2'h0};
		cmd_valid = 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("frozen_ready_err", 64'h2, {62'h0, ready, err});
		cmd_valid = 1'b0;
		en = 1'b1;
		op(fbp_pkg::OP_EXIT, '0, '0, 2'h0, 1'b1);
		op(fbp_pkg::OP_PROG_NVP, B1, '0, 2'h0, 1'b1);
		chk("mode", 64'h0, {62'h0, mode});
		ok(fbp_pkg::OP_ENTER_LOCKREG, '0, '0);
		op(fbp_pkg::OP_PROG_LOCKREG, '0, 64'hfffb, 2'h0, 1'b1);
		chk("no_activate", 64'h0, {63'h0, pwd_mode});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		$display("test refuse done");
	endtask

	task automatic t_pwd();
		ok(fbp_pkg::OP_ENTER_PWD, '0, '0);
		chk("mode", 64'h2, {62'h0, mode});
		for (int i = 0; i < 4; i++) begin
			op(fbp_pkg::OP_PROG_PWD, '0, PW, i[1:0], 1'b0);
		end
		chk("stored", PW, fbp_flash_model_i.pwd);
		ok(fbp_pkg::OP_READ_PWD, '0, '0);
		chk("readback", PW, rdata);
		chk("pwd_ok", 64'h1, {63'h0, pwd_ok});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		chk("exit_cycles", 64'h26, 64'(n));
		chk("mode", 64'h0, {62'h0, mode});
		$display("test password done");
	endtask

	task automatic t_nvp();
		ok(fbp_pkg::OP_ENTER_NVP, '0, '0);
		chk("mode", 64'h3, {62'h0, mode});
		ok(fbp_pkg::OP_PROG_NVP, B1, '0);
		ok(fbp_pkg::OP_READ_NVP, B1, '0);
		chk("nv_b1", 64'h0, {63'h0, rdata[0]});
		ok(fbp_pkg::OP_READ_NVP, B2, '0);
		chk("nv_b2", 64'h1, {63'h0, rdata[0]});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		ok(fbp_pkg::OP_READ_STATUS, B1, '0);
		chk("stat_b1", 64'h1, {56'h0, rdata[7:0]});
		ok(fbp_pkg::OP_READ_STATUS, B2, '0);
		chk("stat_b2", 64'h0, {56'h0, rdata[7:0]});
		$display("test nonvolatile done");
	endtask

	task automatic t_lock();
		ok(fbp_pkg::OP_ENTER_LOCKREG, '0, '0);
		chk("mode", 64'h1, {62'h0, mode});
		ok(fbp_pkg::OP_PROG_LOCKREG, '0, 64'hfffb);
		chk("pwd_mode", 64'h1, {63'h0, pwd_mode});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		flash_rst_n = 1'b0;
		@(posedge clk_i);
		#1;
		flash_rst_n = 1'b1;
		chk("lock_bit", 64'h0, {63'h0, fbp_flash_model_i.lock_b});
		chk("vol_bits", 64'hff, {56'h0, fbp_flash_model_i.vb});
		ok(fbp_pkg::OP_ENTER_PWD, '0, '0);
		op(fbp_pkg::OP_PROG_PWD, '0, 64'h0, 2'h0, 1'b1);
		op(fbp_pkg::OP_READ_PWD, '0, '0, 2'h0, 1'b1);
		ok(fbp_pkg::OP_UNLOCK_PWD, '0, ~PW);
		ok(fbp_pkg::OP_EXIT, '0, '0);
		ok(fbp_pkg::OP_ENTER_NVP, '0, '0);
		ok(fbp_pkg::OP_CLEAR_NVP, '0, '0);
		ok(fbp_pkg::OP_PROG_NVP, B2, '0);
		ok(fbp_pkg::OP_READ_NVP, B1, '0);
		chk("frozen_b1", 64'h0, {63'h0, rdata[0]});
		ok(fbp_pkg::OP_READ_NVP, B2, '0);
		chk("frozen_b2", 64'h1, {63'h0, rdata[0]});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		ok(fbp_pkg::OP_ENTER_PWD, '0, '0);
		ok(fbp_pkg::OP_UNLOCK_PWD, '0, PW);
		ok(fbp_pkg::OP_EXIT, '0, '0);
		chk("unlocked", 64'h1, {63'h0, fbp_flash_model_i.lock_b});
		ok(fbp_pkg::OP_ENTER_NVP, '0, '0);
		ok(fbp_pkg::OP_CLEAR_NVP, '0, '0);
		ok(fbp_pkg::OP_READ_NVP, B1, '0);
		chk("cleared_b1", 64'h1, {63'h0, rdata[0]});
		ok(fbp_pkg::OP_EXIT, '0, '0);
		$display("test lock done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		t_refuse();
		t_pwd();
		t_nvp();
		t_lock();
		final_report();
	end
endmodule
